/* src/sac_pkg.sv */
/*
  Shared constants and types for the sampling converter control block.
  Assumes a 100 MHz system clock from which the conversion clock is divided.
*/
package sac_pkg;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int CONV_CLK_HZ = 2_500_000;
  localparam int CONV_HALF_CYC = SYS_CLK_HZ / (2 * CONV_CLK_HZ);
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_HALF_CYC - 1);
  // Host-side start spacing, kept for reference by the far end
  localparam int START_SPACING_NS = 10_000;
  localparam int START_SPACING_CYC = (START_SPACING_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STROBE_MAX_CONV = 3;

  localparam int RES_W = 12;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [RES_W-1:0] SAR_MSB_TRIAL = 12'h800;

  // Conversion-clock tick schedule inside a frame
  localparam logic [4:0] TICK_SAR_LOAD = 5'h02;
  localparam logic [4:0] TICK_FIRST_DECIDE = 5'h03;
  localparam logic [4:0] TICK_LAST_DECIDE = 5'h0e;
  localparam logic [4:0] TICK_LEAD_ZEROS = 5'h04;
  localparam logic [4:0] TICK_LAST_BIT = 5'h0f;
  localparam logic [4:0] TICK_DONE = 5'h10;

  // Three-level format input as seen by the logic
  localparam logic [1:0] FMT_GATED = 2'h0;
  localparam logic [1:0] FMT_CONT = 2'h1;
  localparam logic [1:0] FMT_PARALLEL = 2'h2;

  // Pin positions inside the shared data pins in byte or serial format
  localparam int PIN_HALF_SEL = 11;
  localparam int PIN_STROBE = 10;
  localparam int PIN_SCLK = 9;
  localparam int PIN_SERIAL_BIT_OUT = 8;

  typedef struct packed {
    logic conversionStartN;
    logic chipSelectN;
    logic readN;
    logic byteHalfSelect;
    logic compBit;
    logic [1:0] fmtSel;
  } sac_pins_type;

  localparam sac_pins_type PINS_RST = 7'h70;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } sac_state_type;
endpackage

/* src/sac_pair_buffer.sv */
/*
  Two-entry result buffer with valid/ready on both sides.
  Assumes one clock and an active-high asynchronous reset; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module sac_pair_buffer #(
  parameter int WIDTH = sac_pkg::RES_W,
  parameter int DEPTH = sac_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] memR [DEPTH];
  logic [PTR_W-1:0] wrPtrR;
  logic [PTR_W-1:0] rdPtrR;
  logic [PTR_W:0] countR;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = (countR != (PTR_W+1)'(DEPTH));
  assign outValid = (countR != '0);
  assign outData = memR[rdPtrR];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtrR <= '0;
      rdPtrR <= '0;
      countR <= '0;
    end
    else
    begin
      if (push)
        wrPtrR <= wrPtrR + 1'b1;
      if (pop)
        rdPtrR <= rdPtrR + 1'b1;
      countR <= countR + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // Storage needs no reset; it is never read while empty
  always_ff @(posedge clk)
  begin
    if (push)
      memR[wrPtrR] <= inData;
  end
endmodule

/* src/sac_adc_ctrl.sv */
/*
  Control and output formatting of a 12-bit successive-approximation converter.
  Assumes pins arrive asynchronously, an analog comparator drives compBit from the
  held sample against dacCode, and the testbench resolves pin levels from the enables.
*/
// Summary of operation
// - Format at positive level: result only as one 12-bit parallel word.
// - Format at ground: byte or serial output, serial clock gated off when idle.
// - Format at negative level: byte or serial output, serial clock runs continuously.
// - Falling start edge switches track to hold and begins a conversion.
// - Start edge accepted only while idle with room in the buffer, independent of chip select and read.
// - Device is selected only while chip select is low.
// - Byte mode: half select high gives zeros and bits 11..8, low gives 7..0.
// - Result is 12-bit two's complement, one step is full scale over 4096.
// - Codes span 0111 1111 1111 down to 1000 0000 0000.
// - A successive-approximation register drives the DAC against the held sample.
// - Data outputs driven only while read and chip select are both low; in byte or serial format pins 10..8 pull low independent of read.
// - Interrupt high during conversion, low when ready, released by first read.
// - Serial word: four zeros then 12 result bits MSB first, framed by strobe.
// - Serial data changes on rising clock; strobe low within three clocks of start.
`timescale 1ns/1ps
module sac_adc_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire sac_pkg::sac_pins_type pinsIn,
  output logic [sac_pkg::RES_W-1:0] dbOut,
  output logic [sac_pkg::RES_W-1:0] dbOe,
  output logic intN,
  output logic holdActive,
  output logic [sac_pkg::RES_W-1:0] dacCode
);
  localparam int PW = $bits(sac_pkg::sac_pins_type);
  localparam int STRB_LIM = sac_pkg::STROBE_MAX_CONV * 2 * sac_pkg::CONV_HALF_CYC;

  logic [PW-1:0] sync1R;
  logic [PW-1:0] sync2R;
  logic [PW-1:0] sync3R;
  sac_pkg::sac_pins_type filtR;
  logic startPrevR;
  logic readPrevR;
  logic [sac_pkg::DIV_W-1:0] divCntR;
  logic convClkR;
  sac_pkg::sac_state_type stateR;
  sac_pkg::sac_state_type stateNxt;
  logic [4:0] tickCntR;
  logic [sac_pkg::RES_W-1:0] sarR;
  logic [sac_pkg::RES_W-1:0] sarNxt;
  logic frameR;
  logic serialBitOutR;
  logic [sac_pkg::RES_W-1:0] outWordR;
  logic [sac_pkg::RES_W-1:0] dbOutR;
  logic [sac_pkg::RES_W-1:0] dbOeR;
  logic intNR;
  logic holdR;
  logic bufInReady;
  logic bufOutValid;
  logic [sac_pkg::RES_W-1:0] bufOutData;

  // Three-stage synchroniser; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sync1R[gi] <= sac_pkg::PINS_RST[gi];
          sync2R[gi] <= sac_pkg::PINS_RST[gi];
          sync3R[gi] <= sac_pkg::PINS_RST[gi];
        end
        else
        begin
          sync1R[gi] <= pinsIn[gi];
          sync2R[gi] <= sync1R[gi];
          sync3R[gi] <= sync2R[gi];
        end
      end
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          filtR[gi] <= sac_pkg::PINS_RST[gi];
        else if (sync2R[gi] == sync3R[gi])
          filtR[gi] <= sync3R[gi];
      end
    end
  endgenerate

  // Decoding of the filtered pins
  wire startFall = startPrevR && !filtR.conversionStartN;
  wire readAct = !filtR.chipSelectN && !filtR.readN;
  wire readFall = readAct && !readPrevR;
  wire fmtPar = (filtR.fmtSel == sac_pkg::FMT_PARALLEL);
  wire fmtCont = (filtR.fmtSel == sac_pkg::FMT_CONT);
  wire idle = (stateR == sac_pkg::ST_IDLE);
  wire run = (stateR == sac_pkg::ST_RUN);
  // A full buffer refuses the start so that no finished word is lost
  wire startAccept = startFall && idle && bufInReady;
  wire riseTick = (divCntR == sac_pkg::DIV_LAST) && !convClkR;
  wire fallTick = (divCntR == sac_pkg::DIV_LAST) && convClkR;
  wire tickRun = run && riseTick;
  wire doneEv = tickRun && (tickCntR == sac_pkg::TICK_DONE);
  wire sarLoad = tickRun && (tickCntR == sac_pkg::TICK_SAR_LOAD);
  wire sarStep = tickRun && (tickCntR >= sac_pkg::TICK_FIRST_DECIDE) && (tickCntR <= sac_pkg::TICK_LAST_DECIDE);
  wire [3:0] bitIdx = 4'(sac_pkg::TICK_LAST_DECIDE - tickCntR);
  wire [3:0] serIdx = 4'(sac_pkg::TICK_LAST_BIT - tickCntR);
  // Offset-binary SAR code becomes two's complement by inverting the MSB
  wire [sac_pkg::RES_W-1:0] twosWord = {~sarR[sac_pkg::RES_W-1], sarR[sac_pkg::RES_W-2:0]};
  // First leading zero comes from the bit cleared at frame start, the next three from the padded top of the frame word
  wire [15:0] serWord = {4'h0, twosWord};
  wire serBitNxt = serWord[serIdx];
  // Reader stall: the output word is frozen while a read is in progress,
  // and a presented word waits until it is read or a new start is accepted, so that no buffered result is lost
  wire drainGo = bufOutValid && intNR && !readAct && idle && !startFall;

  // Per-bit decision and next trial
  generate
    for (gi = 0; gi < sac_pkg::RES_W; gi++)
    begin : g_sar
      assign sarNxt[gi] = (bitIdx == 4'(gi)) ? filtR.compBit :
        ((bitIdx == 4'(gi + 1)) ? 1'b1 : sarR[gi]);
    end
  endgenerate

  // Pin map
  wire sclkLvl = (fmtCont || frameR) ? convClkR : 1'b1;
  wire [sac_pkg::BYTE_W-1:0] byteWord = filtR.byteHalfSelect ?
    {4'h0, outWordR[11:8]} : outWordR[7:0];
  wire [sac_pkg::RES_W-1:0] dbOutNxt = fmtPar ? outWordR : {4'h0, byteWord};
  wire [sac_pkg::RES_W-1:0] dbOeNxt = fmtPar ? {sac_pkg::RES_W{readAct}} :
    {1'b0, frameR, ~sclkLvl, ~serialBitOutR, {sac_pkg::BYTE_W{readAct}}};
  wire intNNxt = drainGo ? 1'b0 : ((readFall || startAccept) ? 1'b1 : intNR);

  always_comb
  begin
    stateNxt = stateR;
    unique case (stateR)
      sac_pkg::ST_IDLE:
        if (startAccept)
          stateNxt = sac_pkg::ST_ARM;
      sac_pkg::ST_ARM:
        if (riseTick)
          stateNxt = sac_pkg::ST_RUN;
      sac_pkg::ST_RUN:
        if (doneEv)
          stateNxt = sac_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      startPrevR <= 1'b1;
      readPrevR <= 1'b0;
      divCntR <= '0;
      convClkR <= 1'b0;
      stateR <= sac_pkg::ST_IDLE;
    end
    else
    begin
      startPrevR <= filtR.conversionStartN;
      readPrevR <= readAct;
      divCntR <= (divCntR == sac_pkg::DIV_LAST) ? '0 : divCntR + 1'b1;
      convClkR <= (divCntR == sac_pkg::DIV_LAST) ? ~convClkR : convClkR;
      stateR <= stateNxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tickCntR <= '0;
      sarR <= '0;
      frameR <= 1'b0;
      serialBitOutR <= 1'b0;
      holdR <= 1'b0;
    end
    else
    begin
      if (stateR == sac_pkg::ST_ARM && riseTick)
        tickCntR <= 5'h01;
      else if (tickRun)
        tickCntR <= tickCntR + 5'h01;
      if (sarLoad)
        sarR <= sac_pkg::SAR_MSB_TRIAL;
      else if (sarStep)
        sarR <= sarNxt;
      if (stateR == sac_pkg::ST_ARM && riseTick)
        frameR <= 1'b1;
      else if (doneEv)
        frameR <= 1'b0;
      if (stateR == sac_pkg::ST_ARM && riseTick)
        serialBitOutR <= 1'b0;
      else if (tickRun && !doneEv)
        serialBitOutR <= serBitNxt;
      if (startAccept)
        holdR <= 1'b1;
      else if (doneEv)
        holdR <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      outWordR <= '0;
      dbOutR <= '0;
      dbOeR <= '0;
      intNR <= 1'b1;
    end
    else
    begin
      if (drainGo)
        outWordR <= bufOutData;
      dbOutR <= dbOutNxt;
      dbOeR <= dbOeNxt;
      intNR <= intNNxt;
    end
  end

  sac_pair_buffer #(
    .WIDTH(sac_pkg::RES_W),
    .DEPTH(sac_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(doneEv),
    .inReady(bufInReady),
    .inData(twosWord),
    .outValid(bufOutValid),
    .outReady(drainGo),
    .outData(bufOutData)
  );

  assign dbOut = dbOutR;
  assign dbOe = dbOeR;
  assign intN = intNR;
  assign holdActive = holdR;
  assign dacCode = sarR;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  start_hold_a: assert property (startAccept |=> holdR [*2]) else $error("hold not entered on start");
  busy_ignore_a: assert property ((!idle && startFall && !doneEv) |=> (stateR != sac_pkg::ST_IDLE))
    else $error("start during conversion disturbed it");
  strobe_low_a: assert property (startAccept |-> ##[1:STRB_LIM] frameR) else $error("strobe late");
  int_busy_a: assert property (holdR |-> intNR) else $error("interrupt low during conversion");
  int_release_a: assert property ((readFall && intNR == 1'b0) |=> intNR) else $error("read did not release interrupt");
  oe_read_a: assert property ((!fmtPar && !readAct) |=> (dbOeR[7:0] == 8'h00)) else $error("bus driven without read");
  parallel_word_a: assert property ((fmtPar && readAct) |=> (dbOeR == 12'hfff && dbOutR == $past(outWordR)))
    else $error("parallel word wrong");
  byte_high_a: assert property ((!fmtPar && readAct && filtR.byteHalfSelect) |=>
    (dbOutR[7:0] == {4'h0, $past(outWordR[11:8])})) else $error("high byte wrong");
  sclk_gated_a: assert property ((filtR.fmtSel == sac_pkg::FMT_GATED && !frameR) |=> !dbOeR[sac_pkg::PIN_SCLK])
    else $error("serial clock not gated");
  sclk_cont_a: assert property ((fmtCont && $past(fmtCont) && fallTick) |=> ##1 dbOeR[sac_pkg::PIN_SCLK])
    else $error("serial clock not running");
  lead_zero_a: assert property ((tickRun && tickCntR < sac_pkg::TICK_LEAD_ZEROS) |=> !serialBitOutR)
    else $error("leading bit not zero");

  frame_c: cover property (frameR ##1 !frameR);
  parallel_read_c: cover property (fmtPar && readFall && !intNR);
  byte_high_c: cover property (!fmtPar && readAct && filtR.byteHalfSelect);
  stall_c: cover property (!bufInReady && startFall);
endmodule

/* tb/sac_host_model.sv */
/*
  Far-side model: analog comparator against the held sample, pull-ups on the serial lines.
  Assumes the device's output enables are high while it pulls a line low.
*/
`timescale 1ns/1ps
module sac_host_model (
  input wire logic holdActive,
  input wire logic [11:0] dacCode,
  input wire logic [11:0] dbOut,
  input wire logic [11:0] dbOe,
  input wire logic [11:0] sampleIn,
  output logic compBit,
  output logic sclkLevel,
  output logic [15:0] serialWord,
  output int serialBits
);
  logic [11:0] held = 12'h000;
  logic strobeLevel;
  logic sdataLevel;
  // Frozen at hold, so later input moves cannot leak in
  always @(posedge holdActive) held = sampleIn;
  assign compBit = held >= dacCode;
  // Released open-drain lines float to the pull-up
  assign strobeLevel = dbOe[10] ? dbOut[10] : 1'b1;
  assign sclkLevel = dbOe[9] ? dbOut[9] : 1'b1;
  assign sdataLevel = dbOe[8] ? dbOut[8] : 1'b1;
  always @(negedge strobeLevel) serialBits = 0;
  always @(negedge sclkLevel)
    if (!strobeLevel)
    begin
      serialWord = {serialWord[14:0], sdataLevel};
      serialBits = serialBits + 1;
    end
endmodule

/* tb/tb.sv */
/*
  Self-checking bench for the converter control block.
  Assumes sac_host_model stands for the comparator and the pulled-up serial lines.
*/
`timescale 1ns/1ps
module tb;
  logic clk;
  logic sys_rst;
  sac_pkg::sac_pins_type pins;
  sac_pkg::sac_pins_type pinsAll;
  logic [11:0] dbOut;
  logic [11:0] dbOe;
  logic [11:0] dacCode;
  logic [11:0] sample;
  logic intN;
  logic holdActive;
  logic compBit;
  logic sclkLevel;
  logic [15:0] serialWord;
  int serialBits;
  int sclkEdges;
  int fails;
  int testsRun;
  logic [11:0] expQ[$];
  logic [1:0] fmts[3] = '{sac_pkg::FMT_PARALLEL, sac_pkg::FMT_GATED, sac_pkg::FMT_CONT};

  assign pinsAll = {pins.conversionStartN, pins.chipSelectN, pins.readN, pins.byteHalfSelect, compBit, pins.fmtSel};

  sac_adc_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .pinsIn(pinsAll), .dbOut(dbOut), .dbOe(dbOe),
    .intN(intN), .holdActive(holdActive), .dacCode(dacCode));
  sac_host_model i_host (.holdActive(holdActive), .dacCode(dacCode), .dbOut(dbOut), .dbOe(dbOe),
    .sampleIn(sample), .compBit(compBit), .sclkLevel(sclkLevel), .serialWord(serialWord),
    .serialBits(serialBits));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(sclkLevel) sclkEdges++;

  task automatic test_done();
    if (fails == 0 && testsRun > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chkWord(input logic [15:0] got, input logic [15:0] want);
    testsRun++;
    if (got !== want)
    begin
      fails++;
      $display("BAD %0t word %h expected %h", $time, got, want);
    end
  endtask

  task automatic chkFlag(input logic got, input logic want);
    testsRun++;
    if (got !== want)
    begin
      fails++;
      $display("BAD %0t flag %b expected %b", $time, got, want);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Read strobe alone must leave the bus floating; pins pass a filter, hence 6 cycles
  task automatic readOne(input logic hbe, output logic [11:0] oe, output logic [11:0] d);
    pins.byteHalfSelect = hbe;
    pins.readN = 1'b0;
    step(6);
    chkWord(16'(dbOe & 12'h8ff), 16'h0000);
    pins.chipSelectN = 1'b0;
    step(6);
    oe = dbOe;
    d = dbOut;
    chkFlag(intN, 1'b1);
    pins.chipSelectN = 1'b1;
    pins.readN = 1'b1;
    step(6);
    chkWord(16'(dbOe & 12'h8ff), 16'h0000);
  endtask

  task automatic readResult(input logic [1:0] fmt);
    logic [11:0] e;
    logic [11:0] oe;
    logic [11:0] d;
    e = expQ.pop_front();
    if (fmt == sac_pkg::FMT_PARALLEL)
    begin
      readOne(1'b0, oe, d);
      chkWord(16'(oe), 16'h0fff);
      chkWord(16'(d), 16'(e));
    end
    else
    begin
      readOne(1'b1, oe, d);
      chkWord(16'(oe & 12'h8ff), 16'h00ff);
      chkWord(16'(d[7:0]), 16'(e[11:8]));
      readOne(1'b0, oe, d);
      chkWord(16'(d[7:0]), 16'(e[7:0]));
    end
  endtask

  task automatic startPulse(input logic [11:0] v);
    sample = v;
    pins.conversionStartN = 1'b0;
    step(6);
    pins.conversionStartN = 1'b1;
  endtask

  // Start with chip select low, then a stray start mid-conversion
  task automatic conv(input logic [1:0] fmt, input logic [11:0] v);
    int i;
    pins.fmtSel = fmt;
    pins.chipSelectN = 1'b0;
    step(10);
    expQ.push_back(v ^ 12'h800);
    startPulse(v);
    pins.chipSelectN = 1'b1;
    step(2);
    chkFlag(holdActive, 1'b1);
    chkFlag(intN, 1'b1);
    step(200);
    startPulse(~v);
    for (i = 0; i < 2000 && intN !== 1'b0; i++)
      step(1);
    chkFlag(intN, 1'b0);
    chkFlag(holdActive, 1'b0);
    if (fmt != sac_pkg::FMT_PARALLEL)
    begin
      chkWord(16'(serialBits), 16'h0010);
      chkWord(serialWord, 16'(v ^ 12'h800));
    end
    sclkEdges = 0;
    step(200);
    chkFlag(sclkEdges > 0, fmt == sac_pkg::FMT_CONT);
    chkFlag(holdActive, 1'b0);
    readResult(fmt);
    step(100);
  endtask

  initial
  begin
    int k;
    logic [11:0] v;
    fails = 0;
    testsRun = 0;
    sclkEdges = 0;
    pins = sac_pkg::PINS_RST;
    sys_rst = 1'b1;
    sample = 12'($urandom(32'h60484785));
    step(8);
    chkWord(16'(dbOe), 16'h0000);
    chkFlag(intN, 1'b1);
    chkFlag(holdActive, 1'b0);
    sys_rst = 1'b0;
    foreach (fmts[f])
    begin
      conv(fmts[f], 12'h000);
      conv(fmts[f], 12'hfff);
      conv(fmts[f], 12'($urandom));
    end
    // A held read stalls draining: two results fill the buffer, the third start is refused
    pins.fmtSel = sac_pkg::FMT_PARALLEL;
    pins.chipSelectN = 1'b0;
    pins.readN = 1'b0;
    for (k = 0; k < 3; k++)
    begin
      v = 12'($urandom);
      if (k < 2)
        expQ.push_back(v ^ 12'h800);
      startPulse(v);
      step(2);
      chkFlag(holdActive, k < 2);
      step(1000);
    end
    pins.chipSelectN = 1'b1;
    pins.readN = 1'b1;
    step(6);
    chkFlag(intN, 1'b0);
    readResult(sac_pkg::FMT_PARALLEL);
    readResult(sac_pkg::FMT_PARALLEL);
    test_done();
  end

  initial
  begin
    #400000;
    fails++;
    test_done();
  end
endmodule
